// ===== design/cit_timing_defines.svh
// instruction length and cycle cost constants for the timing block
`ifndef CIT_TIMING_DEFINES_SVH
`define CIT_TIMING_DEFINES_SVH
// each entry is {length in bytes, execution cycles}
`define CIT_MOV_A_REG {2'h1, 5'h01}
`define CIT_MOV_A_DIR {2'h2, 5'h02}
`define CIT_MOV_A_IND {2'h1, 5'h02}
`define CIT_MOV_A_IMM {2'h2, 5'h02}
`define CIT_MOV_REG_A {2'h1, 5'h02}
`define CIT_MOV_REG_DIR {2'h2, 5'h04}
`define CIT_MOV_REG_IMM {2'h2, 5'h02}
`define CIT_MOV_DIR_A {2'h2, 5'h03}
`define CIT_MOV_DIR_REG {2'h2, 5'h03}
`define CIT_MOV_DIR_DIR {2'h3, 5'h04}
`define CIT_MOV_DIR_IND {2'h2, 5'h04}
`define CIT_MOV_DIR_IMM {2'h3, 5'h03}
`define CIT_MOV_IND_A {2'h1, 5'h03}
`define CIT_MOV_IND_DIR {2'h2, 5'h03}
`define CIT_MOV_IND_IMM {2'h2, 5'h03}
`define CIT_MOV_DATA_POINTER_IMM {2'h3, 5'h03}
`define CIT_CODE_READ {2'h1, 5'h04}
`define CIT_DATA_MEMORY_MOVE_ON {2'h1, 5'h03}
`define CIT_PUSH {2'h2, 5'h04}
`define CIT_POP {2'h2, 5'h03}
`define CIT_XCH_REG {2'h1, 5'h03}
`define CIT_XCH_DIR {2'h2, 5'h04}
`define CIT_XCH_IND {2'h1, 5'h04}
`define CIT_LOW_NIBBLE_EXCHANGE {2'h1, 5'h04}
`define CIT_ALU_REG {2'h1, 5'h02}
`define CIT_ALU_DIR {2'h2, 5'h03}
`define CIT_ALU_IND {2'h1, 5'h03}
`define CIT_ALU_IMM {2'h2, 5'h02}
`define CIT_LOG_DIR_A {2'h2, 5'h04}
`define CIT_LOG_DIR_IMM {2'h3, 5'h04}
`define CIT_ACC_ONE {2'h1, 5'h01}
`define CIT_CPL_A {2'h1, 5'h02}
`define CIT_BIT_DIR {2'h2, 5'h04}
`define CIT_CARRY_BIT {2'h2, 5'h03}
`define CIT_NOP {2'h1, 5'h01}
// external data memory access cost, counter ceiling and program counter reset value
`define CIT_EXT_BASE_MUX 5'h05
`define CIT_EXT_BASE_SEP 5'h03
`define CIT_EXT_UNDEF 5'h14
`define CIT_CNT_MAX 5'h1F
`define CIT_PC_RESET 16'h0000
`endif

// ===== design/cit_timing_pkg.sv
// types shared by the instruction timing block
package cit_timing_pkg;
   typedef struct packed {
      logic [1:0] len;
      logic [4:0] cyc;
   } cit_timing_t;
   typedef struct packed {
      logic ext;
      logic [1:0] mode;
      logic [1:0] ale;
      logic [1:0] rw;
      logic [1:0] hold;
   } cit_xcfg_t;
   typedef enum logic [2:0] {
      ST_OPCODE = 3'b001,
      ST_OPERAND = 3'b010,
      ST_EXEC = 3'b100
   } cit_state_t;
endpackage

// ===== design/cit_timing.sv
// instruction fetch sequencer and cycle timing of the accumulator core
`timescale 1ns/1ns
`include "cit_timing_defines.svh"
// What this block does
// - register to accumulator, one cycle
// - accumulator to register, two cycles
// - direct into register, two bytes, four
// - direct to direct, three bytes, four
// - immediate to direct, three bytes, three
// - direct to indirect RAM, three cycles
// - load data pointer, three bytes, three
// - code memory reads take four cycles
// - on-chip auxiliary RAM moves, three cycles
// - external moves take three to twenty
// - external cost follows interface mode formula
// - push four cycles, pop three cycles
// - exchange direct with accumulator, four cycles
// - low nibble exchange, one byte, four
// - add/subtract: register/immediate two, others three
// - logic from indirect RAM, three cycles
// - logic immediate into direct, four cycles
// - logic accumulator into direct, four cycles
// - rotates and swap take one cycle
// - carry logic with bit, three cycles
module cit_timing
   import cit_timing_pkg::*;
(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET,
   // program memory
   output logic CODE_REQ,
   output logic [15:0] CODE_ADDR,
   input wire logic [7:0] CODE_DATA,
   input wire logic CODE_VALID,
   // data memory move configuration
   input wire cit_timing_pkg::cit_xcfg_t XRAM_CFG,
   // instruction report
   output logic INSTR_START,
   output logic INSTR_DONE,
   output cit_timing_pkg::cit_timing_t INSTR_INFO,
   output logic [7:0] INSTR_OPCODE,
   output logic [15:0] INSTR_OPERANDS,
   output logic UNKNOWN_OP,
   output logic MODE_UNDEF
);
   import cit_timing_pkg::*;

   cit_state_t st_reg, st_next;
   cit_timing_t info_reg, info_next, dec_t, cur_t;
   logic [4:0] cnt_reg, cnt_next, cnt_inc;
   logic [1:0] got_reg, got_next;
   logic [15:0] pc_reg, pc_next, opnd_reg, opnd_next;
   logic [7:0] op_reg, op_next;
   logic unk_reg, unk_next, mund_reg, mund_next;
   logic dec_data_move, dec_known, mund_now, take, done, req;

   // opcode to length and cycle cost
   always_comb begin
      dec_t = `CIT_NOP;
      dec_data_move = 1'b0;
      dec_known = 1'b1;
      casez (CODE_DATA)
         8'h00: dec_t = `CIT_NOP;
         8'b1110_1???: dec_t = `CIT_MOV_A_REG;
         8'hE5: dec_t = `CIT_MOV_A_DIR;
         8'b1110_011?: dec_t = `CIT_MOV_A_IND;
         8'h74: dec_t = `CIT_MOV_A_IMM;
         8'b1111_1???: dec_t = `CIT_MOV_REG_A;
         8'b1010_1???: dec_t = `CIT_MOV_REG_DIR;
         8'b0111_1???: dec_t = `CIT_MOV_REG_IMM;
         8'hF5: dec_t = `CIT_MOV_DIR_A;
         8'b1000_1???: dec_t = `CIT_MOV_DIR_REG;
         8'h85: dec_t = `CIT_MOV_DIR_DIR;
         8'b1000_011?: dec_t = `CIT_MOV_DIR_IND;
         8'h75: dec_t = `CIT_MOV_DIR_IMM;
         8'b1111_011?: dec_t = `CIT_MOV_IND_A;
         8'b1010_011?: dec_t = `CIT_MOV_IND_DIR;
         8'b0111_011?: dec_t = `CIT_MOV_IND_IMM;
         8'h90: dec_t = `CIT_MOV_DATA_POINTER_IMM;
         8'h93, 8'h83: dec_t = `CIT_CODE_READ;
         8'hE0, 8'hF0, 8'b1110_001?, 8'b1111_001?: begin
            dec_t = `CIT_DATA_MEMORY_MOVE_ON;
            dec_data_move = 1'b1;
         end
         8'hC0: dec_t = `CIT_PUSH;
         8'hD0: dec_t = `CIT_POP;
         8'b1100_1???: dec_t = `CIT_XCH_REG;
         8'hC5: dec_t = `CIT_XCH_DIR;
         8'b1100_011?: dec_t = `CIT_XCH_IND;
         8'b1101_011?: dec_t = `CIT_LOW_NIBBLE_EXCHANGE;
         8'b0010_1???, 8'b0011_1???, 8'b1001_1???: dec_t = `CIT_ALU_REG;
         8'h25, 8'h35, 8'h95: dec_t = `CIT_ALU_DIR;
         8'b0010_011?, 8'b0011_011?, 8'b1001_011?: dec_t = `CIT_ALU_IND;
         8'h24, 8'h34, 8'h94: dec_t = `CIT_ALU_IMM;
         8'b0101_1???, 8'b0100_1???, 8'b0110_1???: dec_t = `CIT_ALU_REG;
         8'h55, 8'h45, 8'h65: dec_t = `CIT_ALU_DIR;
         8'h54, 8'h44, 8'h64: dec_t = `CIT_ALU_IMM;
         8'b0101_011?, 8'b0100_011?, 8'b0110_011?: dec_t = `CIT_ALU_IND;
         8'h53, 8'h43, 8'h63: dec_t = `CIT_LOG_DIR_IMM;
         8'h52, 8'h42, 8'h62: dec_t = `CIT_LOG_DIR_A;
         8'h23, 8'h33, 8'h03, 8'h13, 8'hC4: dec_t = `CIT_ACC_ONE;
         8'hE4, 8'hC3, 8'hD3, 8'hB3: dec_t = `CIT_ACC_ONE;
         8'hF4: dec_t = `CIT_CPL_A;
         8'hC2, 8'hD2, 8'hB2: dec_t = `CIT_BIT_DIR;
         8'h82, 8'hB0, 8'h72, 8'hA0: dec_t = `CIT_CARRY_BIT;
         // opcodes outside this block's groups run as one byte, one cycle
         default: dec_known = 1'b0;
      endcase
   end

   // external data memory cost replaces the on-chip figure
   always_comb begin
      cur_t = dec_t;
      mund_now = 1'b0;
      if (dec_data_move && XRAM_CFG.ext) begin
         case (XRAM_CFG.mode)
            2'b00: cur_t.cyc = `CIT_EXT_BASE_MUX + {2'b00, XRAM_CFG.ale, 1'b0}
               + {3'b000, XRAM_CFG.rw} + {2'b00, XRAM_CFG.hold, 1'b0};
            2'b01, 2'b10: cur_t.cyc = `CIT_EXT_BASE_SEP + {3'b000, XRAM_CFG.rw}
               + {2'b00, XRAM_CFG.hold, 1'b0};
            // undefined mode: take the slowest legal cost and flag it
            default: begin
               cur_t.cyc = `CIT_EXT_UNDEF;
               mund_now = 1'b1;
            end
         endcase
      end
   end

   // saturating so a long fetch stall cannot wrap the count
   assign cnt_inc = (cnt_reg == `CIT_CNT_MAX) ? cnt_reg : cnt_reg + 5'h01;

   // fetch and execution sequencer
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      got_next = got_reg;
      pc_next = pc_reg;
      info_next = info_reg;
      op_next = op_reg;
      opnd_next = opnd_reg;
      unk_next = unk_reg;
      mund_next = mund_reg;
      take = 1'b0;
      done = 1'b0;
      req = 1'b0;
      case (st_reg)
         ST_OPCODE: begin
            req = 1'b1;
            if (CODE_VALID) begin
               // first fetch clock is cycle one
               take = 1'b1;
               info_next = cur_t;
               op_next = CODE_DATA;
               opnd_next = 16'h0000;
               unk_next = ~dec_known;
               mund_next = mund_now;
               pc_next = pc_reg + 16'h0001;
               cnt_next = 5'h01;
               got_next = 2'h1;
               if (cur_t.len != 2'h1) begin
                  st_next = ST_OPERAND;
               end else if (cur_t.cyc != 5'h01) begin
                  st_next = ST_EXEC;
               end else begin
                  done = 1'b1;
               end
            end
         end
         ST_OPERAND: begin
            req = 1'b1;
            cnt_next = cnt_inc;
            if (CODE_VALID) begin
               pc_next = pc_reg + 16'h0001;
               got_next = got_reg + 2'h1;
               opnd_next = {opnd_reg[7:0], CODE_DATA};
               if (got_next == info_reg.len) begin
                  if (cnt_inc >= info_reg.cyc) begin
                     done = 1'b1;
                     st_next = ST_OPCODE;
                  end else begin
                     st_next = ST_EXEC;
                  end
               end
            end
         end
         ST_EXEC: begin
            cnt_next = cnt_inc;
            if (cnt_inc >= info_reg.cyc) begin
               done = 1'b1;
               st_next = ST_OPCODE;
            end
         end
         default: st_next = ST_OPCODE;
      endcase
   end

   // sequencer state registers
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         st_reg <= ST_OPCODE;
         cnt_reg <= 5'h00;
         got_reg <= 2'h0;
         pc_reg <= `CIT_PC_RESET;
         info_reg <= `CIT_NOP;
         op_reg <= 8'h00;
         opnd_reg <= 16'h0000;
         unk_reg <= 1'b0;
         mund_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         got_reg <= got_next;
         pc_reg <= pc_next;
         info_reg <= info_next;
         op_reg <= op_next;
         opnd_reg <= opnd_next;
         unk_reg <= unk_next;
         mund_reg <= mund_next;
      end
   end

   // outputs: handshakes direct, report fields from flops
   assign CODE_REQ = req;
   assign CODE_ADDR = pc_reg;
   assign INSTR_START = take;
   assign INSTR_DONE = done;
   assign INSTR_INFO = info_reg;
   assign INSTR_OPCODE = op_reg;
   assign INSTR_OPERANDS = opnd_reg;
   assign UNKNOWN_OP = unk_reg;
   assign MODE_UNDEF = mund_reg;

   // checks on the sequencer
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);

   AST_MOV_A_REG: assert property (take && CODE_DATA[7:3] == 5'b11101 |-> done)
      else $error("register to accumulator not single cycle");
   AST_MOV_REG_A: assert property (take && CODE_DATA[7:3] == 5'b11111 |-> !done ##1 done)
      else $error("accumulator to register not two cycles");
   AST_MOV_REG_DIR: assert property (take && CODE_DATA[7:3] == 5'b10101
      |=> INSTR_INFO == `CIT_MOV_REG_DIR)
      else $error("direct into register timing wrong");
   AST_DIR_DIR: assert property (take && CODE_DATA == 8'h85
      |=> INSTR_INFO.len == 2'h3 && INSTR_INFO.cyc == 5'h04)
      else $error("direct to direct timing wrong");
   AST_DATA_POINTER: assert property (take && CODE_DATA == 8'h90
      |=> INSTR_INFO == `CIT_MOV_DATA_POINTER_IMM)
      else $error("data pointer load timing wrong");
   AST_DATA_MEMORY_MOVE_ON: assert property (take && CODE_DATA == 8'hE0 && !XRAM_CFG.ext
      |=> INSTR_INFO == `CIT_DATA_MEMORY_MOVE_ON)
      else $error("on-chip data move not three cycles");
   AST_DATA_MEMORY_MOVE_RANGE: assert property (take && dec_data_move && XRAM_CFG.ext
      |=> INSTR_INFO.cyc >= 5'h03 && INSTR_INFO.cyc <= 5'h14)
      else $error("external move cost out of range");
   AST_DATA_MEMORY_MOVE_SEP: assert property (take && dec_data_move && XRAM_CFG.ext
      && XRAM_CFG.mode == 2'b01
      |=> INSTR_INFO.cyc == 5'h03 + {3'b000, $past(XRAM_CFG.rw)}
         + {2'b00, $past(XRAM_CFG.hold), 1'b0})
      else $error("external move cost does not follow mode");
   AST_ROTATE: assert property (take && CODE_DATA == 8'h23 |-> done)
      else $error("rotate not single cycle");
   AST_ALL_BYTES: assert property (done && st_reg == ST_OPERAND |-> got_next == info_reg.len)
      else $error("instruction ended before all bytes fetched");
   AST_EXEC_END: assert property (done && st_reg == ST_EXEC |-> cnt_inc == info_reg.cyc)
      else $error("execution ended on wrong cycle");
   // the counter moved on the edge into execution, so hold it from there on
   AST_EXEC_QUIET: assert property (st_reg == ST_EXEC |-> !CODE_REQ ##1 $stable(pc_reg))
      else $error("fetch during execution cycles");

   COV_SINGLE: cover property (take && done);
   COV_OPERAND: cover property (take && CODE_DATA == 8'h85 ##[2:8] done);
   COV_EXEC: cover property (st_reg == ST_EXEC && done);
   COV_EXT: cover property (take && dec_data_move && XRAM_CFG.ext && XRAM_CFG.mode == 2'b00);
endmodule

// ===== tb/cit_pmem_model.sv
// program memory partner model for the instruction timing block
`timescale 1ns/1ns
module cit_pmem_model (
   // clock
   input wire logic clk,
   // fetch port
   input wire logic code_req,
   input wire logic [15:0] code_addr,
   output logic [7:0] code_data,
   output logic code_valid,
   // bench control
   input wire logic stall
);
   logic [7:0] mem [0:255];
   logic [7:0] last_reg;
   // a byte is offered only while fetched and not stalled
   assign code_valid = code_req & ~stall;
   // idle bus shows the inverse of the last byte so stale data never matches
   assign code_data = code_valid ? mem[code_addr[7:0]] : ~last_reg;
   // remember the last byte handed over
   always @(posedge clk) begin
      if (code_valid) begin
         last_reg <= code_data;
      end
   end
endmodule

// ===== tb/tb_cpu_instruction_timing.sv
// self-checking bench for the instruction timing block
`timescale 1ns/1ns
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
   $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module tb_cpu_instruction_timing;
   import cit_timing_pkg::*;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic stall = 1'b0;
   logic code_req, code_valid, instr_start, instr_done, unknown_op, mode_undef;
   logic [15:0] code_addr, instr_operands;
   logic [7:0] code_data, instr_opcode;
   cit_xcfg_t xram_cfg = '0;
   cit_xcfg_t cur_cfg = '0;
   cit_timing_t instr_info;
   int fails = 0;
   int cmp_count = 0;
   logic [7:0] q_op[$];
   logic [1:0] q_len[$];
   logic [4:0] q_cyc[$];
   logic q_und[$];
   cit_xcfg_t q_cfg[$];

   // clock at 125 MHz
   always #4 core_clk = ~core_clk;

   cit_timing dut (.CORE_CLK(core_clk), .RESET(reset), .CODE_REQ(code_req),
      .CODE_ADDR(code_addr), .CODE_DATA(code_data), .CODE_VALID(code_valid),
      .XRAM_CFG(xram_cfg), .INSTR_START(instr_start), .INSTR_DONE(instr_done),
      .INSTR_INFO(instr_info), .INSTR_OPCODE(instr_opcode),
      .INSTR_OPERANDS(instr_operands), .UNKNOWN_OP(unknown_op), .MODE_UNDEF(mode_undef));

   cit_pmem_model u_mem (.clk(core_clk), .code_req(code_req), .code_addr(code_addr),
      .code_data(code_data), .code_valid(code_valid), .stall(stall));

   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", cmp_count, fails);
         if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
         end else begin
            $display("Errors were found");
         end
         $finish;
      end
   endtask

   // queue one instruction with its expected length and cost
   task put(input logic [7:0] op, input logic [1:0] len, input logic [4:0] cyc,
      input logic und);
      begin
         q_op.push_back(op);
         q_len.push_back(len);
         q_cyc.push_back(cyc);
         q_und.push_back(und);
         q_cfg.push_back(cur_cfg);
      end
   endtask

   // load the queued program, reset, then time every instruction
   task run_prog(input int stall_n);
      int wp, k, i, n;
      logic [15:0] pc;
      begin
         @(negedge core_clk);
         reset = 1'b1;
         stall = (stall_n > 0);
         xram_cfg = q_cfg[0];
         wp = 0;
         for (k = 0; k < 256; k++) u_mem.mem[k] = 8'h00;
         for (k = 0; k < q_op.size(); k++) begin
            u_mem.mem[wp] = q_op[k];
            u_mem.mem[wp + 1] = (q_len[k] > 1) ? 8'hA5 : 8'h00;
            u_mem.mem[wp + 2] = (q_len[k] > 2) ? 8'h3C : 8'h00;
            wp += q_len[k];
         end
         repeat (3) @(negedge core_clk);
         reset = 1'b0;
         // nothing may start while program memory holds back the opcode
         for (k = 0; k < stall_n; k++) begin
            @(negedge core_clk);
            `CHK("start in stall", 1'b0, instr_start)
         end
         stall = 1'b0;
         // let the released stall reach the fetch handshake before looking at it
         #1;
         pc = 16'h0000;
         for (k = 0; k < q_op.size(); k++) begin
            i = 0;
            while (instr_start !== 1'b1 && i < 50) begin
               @(negedge core_clk);
               i++;
            end
            n = 1;
            `CHK("opcode address", pc, code_addr)
            while (instr_done !== 1'b1 && n < 40 && i < 50) begin
               @(negedge core_clk);
               n++;
            end
            if (i == 50 || n == 40) begin
               fails++;
               $display("CHECK FAILED wait limit expected %0h seen %0h", q_op[k], n);
               tally_and_finish();
            end
            if (k + 1 < q_op.size()) xram_cfg = q_cfg[k + 1];
            @(negedge core_clk);
            pc += q_len[k];
            `CHK("cycles taken", q_cyc[k], 5'(n))
            `CHK("length and cost", {q_len[k], q_cyc[k]}, instr_info)
            `CHK("opcode", q_op[k], instr_opcode)
            `CHK("operands", (q_len[k] == 3) ? 16'hA53C : (q_len[k] == 2) ? 16'h00A5
               : 16'h0000, instr_operands)
            `CHK("next address", pc, code_addr)
            `CHK("unknown flag", q_op[k] == 8'hA5, unknown_op)
            `CHK("mode flag", q_und[k], mode_undef)
         end
         q_op = {};
         q_len = {};
         q_cyc = {};
         q_und = {};
         q_cfg = {};
      end
   endtask

   task test_moves;
      begin
         cur_cfg = '0;
         put(8'hE8, 2'h1, 5'h01, 1'b0);
         put(8'hF8, 2'h1, 5'h02, 1'b0);
         put(8'hA8, 2'h2, 5'h04, 1'b0);
         put(8'h85, 2'h3, 5'h04, 1'b0);
         put(8'h75, 2'h3, 5'h03, 1'b0);
         put(8'hA6, 2'h2, 5'h03, 1'b0);
         put(8'h90, 2'h3, 5'h03, 1'b0);
         put(8'h93, 2'h1, 5'h04, 1'b0);
         put(8'h83, 2'h1, 5'h04, 1'b0);
         put(8'hE2, 2'h1, 5'h03, 1'b0);
         put(8'hE0, 2'h1, 5'h03, 1'b0);
         put(8'hF2, 2'h1, 5'h03, 1'b0);
         put(8'hF0, 2'h1, 5'h03, 1'b0);
         put(8'hE5, 2'h2, 5'h02, 1'b0);
         put(8'hE6, 2'h1, 5'h02, 1'b0);
         put(8'h74, 2'h2, 5'h02, 1'b0);
         put(8'h78, 2'h2, 5'h02, 1'b0);
         put(8'hF5, 2'h2, 5'h03, 1'b0);
         put(8'h88, 2'h2, 5'h03, 1'b0);
         put(8'h86, 2'h2, 5'h04, 1'b0);
         put(8'hF6, 2'h1, 5'h03, 1'b0);
         put(8'h76, 2'h2, 5'h03, 1'b0);
         run_prog(0);
         $display("moves test done");
      end
   endtask

   // every interface mode with short, long and mixed stretches
   task test_ext;
      int m, c, x;
      logic [1:0] a, r;
      begin
         for (m = 0; m < 4; m++) begin
            for (c = 0; c < 3; c++) begin
               a = (c == 1) ? 2'h3 : (c == 2) ? 2'h1 : 2'h0;
               r = (c == 1) ? 2'h3 : (c == 2) ? 2'h2 : 2'h0;
               cur_cfg = cit_xcfg_t'{1'b1, 2'(m), a, r, a};
               x = (m == 0) ? 5 + 2 * a + r + 2 * a : (m == 3) ? 20 : 3 + r + 2 * a;
               put((c == 1) ? 8'hF0 : 8'hE2, 2'h1, 5'(x), m == 3);
            end
         end
         run_prog(0);
         $display("external moves test done");
      end
   endtask

   // stack and exchange group, started behind a stalled opcode fetch
   task test_stack_xch;
      begin
         cur_cfg = '0;
         put(8'hC0, 2'h2, 5'h04, 1'b0);
         put(8'hD0, 2'h2, 5'h03, 1'b0);
         put(8'hC5, 2'h2, 5'h04, 1'b0);
         put(8'hD6, 2'h1, 5'h04, 1'b0);
         put(8'hC8, 2'h1, 5'h03, 1'b0);
         put(8'hC6, 2'h1, 5'h04, 1'b0);
         run_prog(3);
         $display("stack and exchange test done");
      end
   endtask

   task test_alu;
      begin
         cur_cfg = '0;
         put(8'h28, 2'h1, 5'h02, 1'b0);
         put(8'h24, 2'h2, 5'h02, 1'b0);
         put(8'h25, 2'h2, 5'h03, 1'b0);
         put(8'h26, 2'h1, 5'h03, 1'b0);
         put(8'h35, 2'h2, 5'h03, 1'b0);
         put(8'h98, 2'h1, 5'h02, 1'b0);
         put(8'h96, 2'h1, 5'h03, 1'b0);
         put(8'h56, 2'h1, 5'h03, 1'b0);
         put(8'h46, 2'h1, 5'h03, 1'b0);
         put(8'h66, 2'h1, 5'h03, 1'b0);
         put(8'h53, 2'h3, 5'h04, 1'b0);
         put(8'h63, 2'h3, 5'h04, 1'b0);
         put(8'h42, 2'h2, 5'h04, 1'b0);
         put(8'h62, 2'h2, 5'h04, 1'b0);
         put(8'h23, 2'h1, 5'h01, 1'b0);
         put(8'h33, 2'h1, 5'h01, 1'b0);
         put(8'h03, 2'h1, 5'h01, 1'b0);
         put(8'h13, 2'h1, 5'h01, 1'b0);
         put(8'hC4, 2'h1, 5'h01, 1'b0);
         put(8'h82, 2'h2, 5'h03, 1'b0);
         put(8'hB0, 2'h2, 5'h03, 1'b0);
         put(8'hA0, 2'h2, 5'h03, 1'b0);
         put(8'h72, 2'h2, 5'h03, 1'b0);
         put(8'h36, 2'h1, 5'h03, 1'b0);
         put(8'h94, 2'h2, 5'h02, 1'b0);
         put(8'hF4, 2'h1, 5'h02, 1'b0);
         put(8'hE4, 2'h1, 5'h01, 1'b0);
         put(8'hC3, 2'h1, 5'h01, 1'b0);
         put(8'hC2, 2'h2, 5'h04, 1'b0);
         put(8'h54, 2'h2, 5'h02, 1'b0);
         put(8'h45, 2'h2, 5'h03, 1'b0);
         put(8'h68, 2'h1, 5'h02, 1'b0);
         put(8'h00, 2'h1, 5'h01, 1'b0);
         // outside the covered groups: one byte, one cycle, flagged
         put(8'hA5, 2'h1, 5'h01, 1'b0);
         run_prog(0);
         $display("arithmetic and logic test done");
      end
   endtask

   // main sequence
   initial begin
      test_moves();
      test_ext();
      test_stack_xch();
      test_alu();
      tally_and_finish();
   end
endmodule
